// [include/dpm_pkg.sv]
package dpm_pkg;
   localparam int ADDR_W = 12;
   localparam int CNT_W = 32;
   localparam int LAT_W = 16;
   localparam int CH_SEL_W = 6;
   localparam int NUM_DMA_CH = 12;
   // register byte offsets
   localparam logic [11:0] OFF_CONTROL = 12'h800;
   localparam logic [11:0] OFF_M0_RD_DATA = 12'h804;
   localparam logic [11:0] OFF_M0_RD_STALL = 12'h808;
   localparam logic [11:0] OFF_M0_RD_LAT = 12'h80C;
   localparam logic [11:0] OFF_M0_WR_DATA = 12'h810;
   localparam logic [11:0] OFF_M0_WR_STALL = 12'h814;
   localparam logic [11:0] OFF_M0_WR_LAT = 12'h818;
   localparam logic [11:0] OFF_M1_RD_DATA = 12'h81C;
   localparam logic [11:0] OFF_M1_RD_STALL = 12'h820;
   localparam logic [11:0] OFF_M1_RD_LAT = 12'h824;
   localparam logic [11:0] OFF_M1_WR_DATA = 12'h828;
   localparam logic [11:0] OFF_M1_WR_STALL = 12'h82C;
   localparam logic [11:0] OFF_M1_WR_LAT = 12'h830;
   // control register fields
   localparam int BIT_EN0 = 0;
   localparam int BIT_EN1 = 1;
   localparam int BIT_OF0 = 4;
   localparam int BIT_OF1 = 5;
   localparam int BIT_CLR0 = 8;
   localparam int BIT_CLR1 = 9;
   localparam int SEL0_LSB = 16;
   localparam int SEL1_LSB = 24;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_RW_MASK = 32'h3F3F_0033;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // per-channel activity from the dma transfer logic
   typedef struct packed {
      logic rd_data;  // read data moved
      logic rd_stall; // read stalled
      logic rd_start; // read request waiting to start
      logic wr_data;
      logic wr_stall;
      logic wr_start;
   } dpm_activity_t;

   // per-monitor control
   typedef struct packed {
      logic enable;
      logic freeze;
      logic clear;
   } dpm_mon_ctrl_t;

   // per-monitor counter values
   typedef struct packed {
      logic [31:0] rd_data;
      logic [31:0] rd_stall;
      logic [15:0] rd_lat;
      logic [31:0] wr_data;
      logic [31:0] wr_stall;
      logic [15:0] wr_lat;
   } dpm_counts_t;
endpackage

// [logic/dpm_monitor.sv]
`timescale 1ns/1ns
module dpm_monitor (
   input wire logic aclk, // hs bus clock
   input wire logic aresetn, // sync reset, low
   input wire dpm_pkg::dpm_mon_ctrl_t ctrl, // enable, freeze, clear
   input wire dpm_pkg::dpm_activity_t act, // selected channel activity
   output dpm_pkg::dpm_counts_t counts // counter values
);
   logic [31:0] rd_data_q;
   logic [31:0] rd_stall_q;
   logic [31:0] wr_data_q;
   logic [31:0] wr_stall_q;
   logic [15:0] rd_max_q;
   logic [15:0] wr_max_q;
   logic [15:0] rlat_q;
   logic [15:0] wlat_q;
   logic near_ovf;
   logic wrapping;

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   // any data/stall counter about to pass its top
   assign near_ovf = ctrl.enable &&
      ((act.rd_data && rd_data_q == 32'hFFFF_FFFF) ||
       (act.rd_stall && rd_stall_q == 32'hFFFF_FFFF) ||
       (act.wr_data && wr_data_q == 32'hFFFF_FFFF) ||
       (act.wr_stall && wr_stall_q == 32'hFFFF_FFFF));
   assign wrapping = near_ovf && !ctrl.freeze;

   // data and stall counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data_q <= '0;
         rd_stall_q <= '0;
         wr_data_q <= '0;
         wr_stall_q <= '0;
      end else if (ctrl.clear || wrapping) begin
         rd_data_q <= '0;
         rd_stall_q <= '0;
         wr_data_q <= '0;
         wr_stall_q <= '0;
      end else if (ctrl.enable && !near_ovf) begin
         rd_data_q <= rd_data_q + 32'(act.rd_data);
         rd_stall_q <= rd_stall_q + 32'(act.rd_stall);
         wr_data_q <= wr_data_q + 32'(act.wr_data);
         wr_stall_q <= wr_stall_q + 32'(act.wr_stall);
      end
   end

   // running initiation latency, in hs bus cycles
   always_ff @(posedge aclk) begin
      if (!aresetn || ctrl.clear) begin
         rlat_q <= '0;
         wlat_q <= '0;
      end else begin
         rlat_q <= act.rd_start ? sat_inc(rlat_q) : '0;
         wlat_q <= act.wr_start ? sat_inc(wlat_q) : '0;
      end
   end

   // maximum latency
   always_ff @(posedge aclk) begin
      if (!aresetn || ctrl.clear) begin
         rd_max_q <= '0;
         wr_max_q <= '0;
      end else if (ctrl.enable && !(near_ovf && ctrl.freeze)) begin
         if (rlat_q > rd_max_q) begin
            rd_max_q <= rlat_q;
         end
         if (wlat_q > wr_max_q) begin
            wr_max_q <= wlat_q;
         end
      end
   end

   assign counts = '{rd_data: rd_data_q, rd_stall: rd_stall_q, rd_lat: rd_max_q,
                     wr_data: wr_data_q, wr_stall: wr_stall_q, wr_lat: wr_max_q};
endmodule // dpm_monitor

// [logic/dpm_top.sv]
`timescale 1ns/1ns
// Functional notes
// - Monitor 0 counts read stall cycles in 32 bits since its clear.
// - Monitor 1 read stall counter, same behaviour, software read only.
// - Monitor 0 counts write data cycles in 32 bits.
// - Monitor 0 counts write stall cycles in 32 bits.
// - Monitor 1 counts read data cycles in 32 bits.
// - Max latency is 16 low bits; upper sixteen read zero.
// - Monitor 0 read max latency register exists.
// - Monitor 0 write max latency register exists.
// - Monitor 1 read max latency register exists.
// - Latency counted in high-speed bus clock cycles.
// - Latency counter saturates at top, never wraps.
// - Monitor 0 latency cleared only by its clear bit.
// - Writing one clears a monitor; zero ignored; bit reads zero.
// - Freeze off: overflow clears data and stall counters, not max latency; on: all frozen before overflow.
// - Each monitor has an enable; disabled monitor holds its counters.
module dpm_top #(
   parameter int NUM_CH = dpm_pkg::NUM_DMA_CH // dma channels watched
) (
   input wire logic aclk, // hs bus clock, 100 MHz
   input wire logic aresetn, // sync reset, low
   input wire logic [11:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire dpm_pkg::dpm_activity_t [NUM_CH-1:0] dma_act // per channel activity
);
   logic [31:0] ctrl_q;
   logic [11:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic [1:0] clr_q;
   logic do_write;
   logic wr_ok;
   logic rd_ok;
   logic [31:0] rd_word;
   dpm_pkg::dpm_mon_ctrl_t mctrl0, mctrl1;
   dpm_pkg::dpm_activity_t act0, act1;
   dpm_pkg::dpm_counts_t cnt0, cnt1;
   logic [5:0] sel0, sel1;

   function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic addr_known(input logic [11:0] a);
      return (a[1:0] == 2'h0) && (a >= dpm_pkg::OFF_CONTROL) &&
             (a <= dpm_pkg::OFF_M1_WR_LAT);
   endfunction

   function automatic dpm_pkg::dpm_activity_t pick(input dpm_pkg::dpm_activity_t [NUM_CH-1:0] a,
                                                  input logic [5:0] s);
      return (32'(s) < NUM_CH) ? a[s] : '0;
   endfunction

   // write channels: address and data taken in either order
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_ok = addr_known(awaddr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 12'h000;
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dpm_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? dpm_pkg::RESP_OKAY : dpm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register; clear bits are not stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= dpm_pkg::CTRL_RESET;
      end else if (do_write && awaddr_q == dpm_pkg::OFF_CONTROL) begin
         ctrl_q <= strb_merge(ctrl_q, wdata_q, wstrb_q) & dpm_pkg::CTRL_RW_MASK;
      end
   end

   // one-cycle clear pulse on writing one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clr_q <= 2'b00;
      end else if (do_write && awaddr_q == dpm_pkg::OFF_CONTROL && wstrb_q[1]) begin
         clr_q <= {wdata_q[dpm_pkg::BIT_CLR1], wdata_q[dpm_pkg::BIT_CLR0]};
      end else begin
         clr_q <= 2'b00;
      end
   end

   assign sel0 = ctrl_q[dpm_pkg::SEL0_LSB +: dpm_pkg::CH_SEL_W];
   assign sel1 = ctrl_q[dpm_pkg::SEL1_LSB +: dpm_pkg::CH_SEL_W];
   assign act0 = pick(dma_act, sel0);
   assign act1 = pick(dma_act, sel1);
   assign mctrl0 = '{enable: ctrl_q[dpm_pkg::BIT_EN0], freeze: ctrl_q[dpm_pkg::BIT_OF0],
                     clear: clr_q[0]};
   assign mctrl1 = '{enable: ctrl_q[dpm_pkg::BIT_EN1], freeze: ctrl_q[dpm_pkg::BIT_OF1],
                     clear: clr_q[1]};

   dpm_monitor u_mon0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(mctrl0),
      .act(act0),
      .counts(cnt0)
   );

   dpm_monitor u_mon1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(mctrl1),
      .act(act1),
      .counts(cnt1)
   );

   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         dpm_pkg::OFF_CONTROL: rd_word = ctrl_q;
         dpm_pkg::OFF_M0_RD_DATA: rd_word = cnt0.rd_data;
         dpm_pkg::OFF_M0_RD_STALL: rd_word = cnt0.rd_stall;
         dpm_pkg::OFF_M0_RD_LAT: rd_word = {16'h0000, cnt0.rd_lat};
         dpm_pkg::OFF_M0_WR_DATA: rd_word = cnt0.wr_data;
         dpm_pkg::OFF_M0_WR_STALL: rd_word = cnt0.wr_stall;
         dpm_pkg::OFF_M0_WR_LAT: rd_word = {16'h0000, cnt0.wr_lat};
         dpm_pkg::OFF_M1_RD_DATA: rd_word = cnt1.rd_data;
         dpm_pkg::OFF_M1_RD_STALL: rd_word = cnt1.rd_stall;
         dpm_pkg::OFF_M1_RD_LAT: rd_word = {16'h0000, cnt1.rd_lat};
         dpm_pkg::OFF_M1_WR_DATA: rd_word = cnt1.wr_data;
         dpm_pkg::OFF_M1_WR_STALL: rd_word = cnt1.wr_stall;
         dpm_pkg::OFF_M1_WR_LAT: rd_word = {16'h0000, cnt1.wr_lat};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   assign rd_ok = addr_known(s_axi_araddr);
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= dpm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? dpm_pkg::RESP_OKAY : dpm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // dpm_top

// [testbench/dpm_top_monitor.sv]
`timescale 1ns/1ns
module dpm_top_monitor (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low
   input wire logic [11:0] s_axi_awaddr, // aw addr
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [11:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   logic [11:0] wa_q;
   logic [11:0] ra_q;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   function automatic logic ok(input logic [11:0] a);
      return a >= 12'h800 && a <= 12'h830 && a[1:0] == 2'h0;
   endfunction
   function automatic logic is_lat(input logic [11:0] a);
      return a == 12'h80C || a == 12'h818 || a == 12'h824 || a == 12'h830;
   endfunction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wa_q <= 12'h000;
         ra_q <= 12'h000;
      end else begin
         if (aw_hs) wa_q <= s_axi_awaddr;
         if (ar_hs) ra_q <= s_axi_araddr;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_ok;
      ar_hs && ok(s_axi_araddr) |=> s_axi_rvalid && s_axi_rresp == 2'h0;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("mapped read not okay");
   property p_rd_err;
      ar_hs && !ok(s_axi_araddr) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   property p_lat_hi;
      s_axi_rvalid && is_lat(ra_q) |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_lat_hi: assert property (p_lat_hi) else $error("latency upper half set");
   property p_clr_zero;
      s_axi_rvalid && ra_q == 12'h800 |-> s_axi_rdata[9:8] == 2'h0;
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clear bit read as one");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_b_after;
      aw_hs && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write response late");
   property p_wr_resp;
      $rose(s_axi_bvalid) |-> s_axi_bresp == (ok(wa_q) ? 2'h0 : 2'h2);
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response code wrong");
   c_lat: cover property (s_axi_rvalid && is_lat(ra_q) && s_axi_rdata != 32'h0);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_wr: cover property ($rose(s_axi_bvalid));
endmodule // dpm_top_monitor

bind dpm_top dpm_top_monitor i_dpm_top_monitor (.*);

// [testbench/dpm_dma_model.sv]
`timescale 1ns/1ns
module dpm_dma_model #(
   parameter int NUM_CH = 12 // dma channels
) (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low
   input wire logic go, // start a burst
   input wire logic [3:0] ch, // channel driven
   input wire dpm_pkg::dpm_activity_t pat, // burst activity
   input wire logic [15:0] len, // burst cycles
   output dpm_pkg::dpm_activity_t [NUM_CH-1:0] act // activity out
);
   logic [15:0] left_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_q <= 16'h0000;
      end else if (go) begin
         left_q <= len;
      end else if (left_q != 16'h0000) begin
         left_q <= left_q - 16'h0001;
      end
   end
   // idle channels show no activity
   always_comb begin
      act = '0;
      if (left_q != 16'h0000) begin
         act[ch] = pat;
      end
   end
endmodule // dpm_dma_model

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, m_go = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF, m_ch = 4'h0;
   logic [15:0] m_len = 16'h0000;
   dpm_pkg::dpm_activity_t m_pat = 6'h00;
   dpm_pkg::dpm_activity_t [11:0] dma_act;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int err_count = 0, n_compared = 0;
   dpm_top i_dpm_top (.*);
   dpm_dma_model i_dpm_dma_model (.aclk(aclk), .aresetn(aresetn), .go(m_go), .ch(m_ch),
      .pat(m_pat), .len(m_len), .act(dma_act));
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] rs);
      logic ta, tw, td, dv;
      rs = 2'h3;
      q = 32'h0;
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
      end
      repeat (40) begin
         #1;
         ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
         tw = s_axi_wvalid && s_axi_wready;
         dv = wr ? s_axi_bvalid : s_axi_rvalid;
         td = dv && (wr ? s_axi_bready : s_axi_rready);
         if (td) begin
            rs = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
         end
         @(posedge aclk);
         if (ta && wr) s_axi_awvalid <= 1'b0;
         if (ta && !wr) s_axi_arvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (wr) s_axi_bready <= dv && !td;
         else s_axi_rready <= dv && !td;
         if (td) break;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      logic [31:0] q;
      logic [1:0] r;
      xfer(1'b1, a, d, q, r);
      chk({30'h0, r}, {30'h0, e});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      xfer(1'b0, a, 32'h0, q, r);
      chk(q, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic burst(input logic [3:0] c, input logic [5:0] p, input logic [15:0] n);
      m_ch <= c;
      m_pat <= p;
      m_len <= n;
      m_go <= 1'b1;
      @(posedge aclk);
      m_go <= 1'b0;
      repeat (n + 3) @(posedge aclk);
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      err_count++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 13; i++) rd(12'h800 + 12'(4 * i), 32'h0, 2'h0);
      $display("reset values done");
      wr(12'h800, 32'h0502_0003, 2'h0);
      rd(12'h800, 32'h0502_0003, 2'h0);
      burst(4'h2, 6'h14, 16'h000A);
      burst(4'h2, 6'h02, 16'h0006);
      burst(4'h5, 6'h30, 16'h0007);
      rd(12'h808, 32'h0000_000A, 2'h0);
      rd(12'h810, 32'h0000_000A, 2'h0);
      rd(12'h814, 32'h0000_0006, 2'h0);
      rd(12'h81C, 32'h0000_0007, 2'h0);
      wr(12'h820, 32'hFFFF_FFFF, 2'h0);
      rd(12'h820, 32'h0000_0007, 2'h0);
      $display("data and stall counts done");
      burst(4'h2, 6'h08, 16'h0005);
      burst(4'h2, 6'h08, 16'h0003);
      burst(4'h2, 6'h01, 16'h0004);
      burst(4'h5, 6'h08, 16'h0006);
      rd(12'h80C, 32'h0000_0005, 2'h0);
      rd(12'h818, 32'h0000_0004, 2'h0);
      rd(12'h824, 32'h0000_0006, 2'h0);
      $display("latency done");
      wr(12'h800, 32'h0502_0103, 2'h0);
      rd(12'h800, 32'h0502_0003, 2'h0);
      rd(12'h808, 32'h0, 2'h0);
      rd(12'h80C, 32'h0, 2'h0);
      rd(12'h820, 32'h0000_0007, 2'h0);
      $display("clear done");
      wr(12'h800, 32'h0502_0002, 2'h0);
      burst(4'h2, 6'h14, 16'h0004);
      rd(12'h808, 32'h0, 2'h0);
      rd(12'h810, 32'h0, 2'h0);
      rd(12'h900, 32'h0, 2'h2);
      wr(12'h900, 32'h0000_0001, 2'h2);
      $display("disable and unmapped done");
      wr(12'h800, 32'h0502_0233, 2'h0);
      rd(12'h800, 32'h0502_0033, 2'h0);
      rd(12'h81C, 32'h0, 2'h0);
      rd(12'h820, 32'h0, 2'h0);
      rd(12'h824, 32'h0, 2'h0);
      $display("freeze and second clear done");
      final_report();
   end
endmodule // tb_top
